// ==== bdoc_pkg.sv ====
package bdoc_pkg;
	// ==========================================================
	// Command framing
	localparam logic [7:0] CMD_PREFIX = 8'hfe;
	localparam logic [7:0] CODE_MDIG_LOAD = 8'h6d;
	localparam logic [7:0] CODE_MDIG_PLACE = 8'h6f;
	localparam logic [7:0] CODE_HBAR_LOAD = 8'h68;
	localparam logic [7:0] CODE_HBAR_PLACE = 8'h7c;
	localparam logic [7:0] CODE_NBAR_LOAD = 8'h73;
	localparam logic [7:0] CODE_WBAR_LOAD = 8'h76;
	localparam logic [7:0] CODE_VBAR_PLACE = 8'h3d;
	localparam logic [7:0] CODE_OUT_ON = 8'h57;
	localparam logic [7:0] CODE_OUT_OFF = 8'h56;
	localparam logic [7:0] CODE_OUT_BOOT = 8'hc3;
	localparam logic [2:0] MDIG_PARAMS = 3'h3;
	localparam logic [2:0] HBAR_PARAMS = 3'h4;
	localparam logic [2:0] VBAR_PARAMS = 3'h2;
	localparam logic [2:0] OUT_PARAMS = 3'h1;
	localparam logic [2:0] BOOT_PARAMS = 3'h2;

	// ==========================================================
	// Screen geometry and ranges
	localparam logic [7:0] SCREEN_COLS = 8'h14;
	localparam logic [7:0] SCREEN_ROWS = 8'h04;
	localparam logic [7:0] HBAR_MAX_LEN = 8'h64;
	localparam logic [7:0] VBAR_MAX_LEN = 8'h20;
	localparam logic [7:0] HBAR_CELL_PX = 8'h05;
	localparam logic [7:0] VBAR_CELL_PX = 8'h08;
	localparam logic [7:0] DIGIT_MAX = 8'h09;
	localparam logic [7:0] DIR_LEFT = 8'h01;
	localparam logic [7:0] STATE_ON = 8'h01;
	localparam logic [4:0] MDIG_STEPS = 5'h02;
	localparam logic [4:0] VBAR_STEPS = 5'h04;

	// ==========================================================
	// Cell character codes
	localparam logic [7:0] BLANK_CHAR = 8'h20;
	localparam logic [7:0] BAR_GLYPH_BASE = 8'h00;
	localparam logic [7:0] MDIG_GLYPH_BASE = 8'h80;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		BANK_NONE = 3'h0,
		BANK_MDIG = 3'h1,
		BANK_HBAR = 3'h2,
		BANK_NBAR = 3'h3,
		BANK_WBAR = 3'h4
	} bdoc_bank_t;

	typedef enum logic [1:0] {
		DRAW_MDIG = 2'h0,
		DRAW_HBAR = 2'h1,
		DRAW_VBAR = 2'h2
	} bdoc_draw_t;
endpackage : bdoc_pkg

// ==== bdoc_draw_if.sv ====
`timescale 1ns/1ps
interface bdoc_draw_if;
	import bdoc_pkg::*;
	logic start;
	bdoc_draw_t kind;
	logic [7:0] col;
	logic [7:0] row;
	logic [7:0] dir;
	logic [7:0] len;
	logic busy;
	logic cell_we;
	logic [2:0] cell_row;
	logic [4:0] cell_col;
	logic [7:0] cell_char;

	modport ctrl (
		output start, kind, col, row, dir, len,
		input busy, cell_we, cell_row, cell_col, cell_char
	);
	modport eng (
		input start, kind, col, row, dir, len,
		output busy, cell_we, cell_row, cell_col, cell_char
	);
endinterface : bdoc_draw_if

// ==== bdoc_draw_engine.sv ====
`timescale 1ns/1ps
module bdoc_draw_engine
	import bdoc_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	bdoc_draw_if.eng drw
);
	// ==========================================================
	// Fill helper
	function automatic logic [7:0] fill_level(input logic [7:0] len,
		input logic [7:0] used, input logic [7:0] cap);
		logic [7:0] rest;
		rest = (len > used) ? 8'(len - used) : 8'h00;
		return (rest > cap) ? cap : rest;
	endfunction : fill_level

	bdoc_draw_t kind_reg;
	logic busy_reg;
	logic [7:0] col_reg;
	logic [7:0] row_reg;
	logic dir_left_reg;
	logic [7:0] len_reg;
	logic [4:0] step_reg;
	logic [4:0] steps_reg;
	logic cell_we_reg;
	logic [2:0] cell_row_reg;
	logic [4:0] cell_col_reg;
	logic [7:0] cell_char_reg;

	// ==========================================================
	// Current cell
	wire [7:0] step8 = {3'h0, step_reg};
	wire [7:0] h_used = 8'(step8 * HBAR_CELL_PX);
	wire [7:0] v_used = 8'(step8 * VBAR_CELL_PX);
	wire [7:0] h_level = fill_level(len_reg, h_used, HBAR_CELL_PX);
	wire [7:0] v_level = fill_level(len_reg, v_used, VBAR_CELL_PX);
	wire [7:0] col_h = dir_left_reg ? 8'(col_reg - step8) :
		8'(col_reg + step8);
	// Digits and vertical bars stay in their one column
	wire [7:0] col_cur = (kind_reg == DRAW_HBAR) ? col_h : col_reg;
	wire [7:0] row_cur = (kind_reg == DRAW_VBAR) ? 8'(8'h01 + step8) :
		(kind_reg == DRAW_MDIG) ? 8'(row_reg + step8) : row_reg;
	wire [7:0] bar_level = (kind_reg == DRAW_VBAR) ? v_level : h_level;
	wire [7:0] bar_char = (bar_level == 8'h00) ? BLANK_CHAR :
		8'(BAR_GLYPH_BASE + bar_level - 8'h01);
	wire [7:0] mdig_char = 8'(MDIG_GLYPH_BASE + {len_reg[6:0], step_reg[0]});
	wire [7:0] char_cur = (kind_reg == DRAW_MDIG) ? mdig_char : bar_char;
	// Bottom half of a digit on the last row falls off the screen
	wire write_ok = (row_cur <= SCREEN_ROWS);
	wire last_step = (5'(step_reg + 5'h01) == steps_reg);
	wire [4:0] hbar_steps = (drw.dir == DIR_LEFT) ? drw.col[4:0] :
		5'(SCREEN_COLS[4:0] + 5'h01 - drw.col[4:0]);
	wire [4:0] steps_start = (drw.kind == DRAW_MDIG) ? MDIG_STEPS :
		(drw.kind == DRAW_VBAR) ? VBAR_STEPS : hbar_steps;

	// ==========================================================
	// Sequencer: one cell per cycle
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			busy_reg <= 1'b0;
			kind_reg <= DRAW_MDIG;
			col_reg <= 8'h00;
			row_reg <= 8'h00;
			dir_left_reg <= 1'b0;
			len_reg <= 8'h00;
			step_reg <= 5'h00;
			steps_reg <= 5'h00;
			cell_we_reg <= 1'b0;
			cell_row_reg <= 3'h0;
			cell_col_reg <= 5'h00;
			cell_char_reg <= 8'h00;
		end else if (!busy_reg) begin
			cell_we_reg <= 1'b0;
			if (drw.start) begin
				busy_reg <= 1'b1;
				kind_reg <= drw.kind;
				col_reg <= drw.col;
				row_reg <= drw.row;
				dir_left_reg <= (drw.dir == DIR_LEFT);
				len_reg <= drw.len;
				step_reg <= 5'h00;
				steps_reg <= steps_start;
			end
		end else begin
			// Trailing cells are blanked so an older bar is erased
			cell_we_reg <= write_ok;
			cell_row_reg <= row_cur[2:0];
			cell_col_reg <= col_cur[4:0];
			cell_char_reg <= char_cur;
			step_reg <= 5'(step_reg + 5'h01);
			if (last_step) begin
				busy_reg <= 1'b0;
			end
		end
	end

	assign drw.busy = busy_reg | cell_we_reg;
	assign drw.cell_we = cell_we_reg;
	assign drw.cell_row = cell_row_reg;
	assign drw.cell_col = cell_col_reg;
	assign drw.cell_char = cell_char_reg;
endmodule : bdoc_draw_engine

// ==== bdoc_top.sv ====
// What this block does
// - Prefix then 109 loads medium-digit bank
// - Place digit: two rows tall, one wide
// - Prefix then 104 loads horizontal bar bank
// - Horizontal bar drawn from cell, replacing old
// - Direction 0 grows right, 1 left
// - Prefix then 115 loads narrow bar bank
// - Prefix then 118 loads wide bar bank
// - Vertical bar from first row, replacing old
// - Output-on drives chosen output high
// - Output-off drives chosen output low
// - Bank load discards unsaved custom characters
`timescale 1ns/1ps
module bdoc_top
	import bdoc_pkg::*;
#(
	parameter int GEN_OUT_COUNT = 8
) (
	input wire logic SYS_CLK_IN,
	input wire logic SRST_IN,
	input wire logic [7:0] RX_DATA_IN,
	input wire logic RX_VALID_IN,
	output logic RX_READY_OUT,
	output logic BANK_LOAD_OUT,
	output logic [2:0] BANK_SEL_OUT,
	output logic [2:0] ACTIVE_BANK_OUT,
	output logic CELL_WE_OUT,
	output logic [2:0] CELL_ROW_OUT,
	output logic [4:0] CELL_COL_OUT,
	output logic [7:0] CELL_CHAR_OUT,
	output logic [GEN_OUT_COUNT-1:0] GENERAL_OUTPUT_OUT,
	input wire logic [GEN_OUT_COUNT-1:0] NV_STATE_IN,
	output logic NV_WE_OUT,
	output logic [7:0] NV_INDEX_OUT,
	output logic NV_STATE_OUT
);
	// ==========================================================
	// Helpers
	function automatic logic in_range(input logic [7:0] v,
		input logic [7:0] lo, input logic [7:0] hi);
		return (v >= lo) && (v <= hi);
	endfunction : in_range

	function automatic logic [2:0] param_count(input logic [7:0] code);
		logic [2:0] n;
		n = 3'h0;
		case (code)
			CODE_MDIG_PLACE: n = MDIG_PARAMS;
			CODE_HBAR_PLACE: n = HBAR_PARAMS;
			CODE_VBAR_PLACE: n = VBAR_PARAMS;
			CODE_OUT_ON: n = OUT_PARAMS;
			CODE_OUT_OFF: n = OUT_PARAMS;
			CODE_OUT_BOOT: n = BOOT_PARAMS;
			default: n = 3'h0;
		endcase
		return n;
	endfunction : param_count

	function automatic logic is_bank_load(input logic [7:0] code);
		return (code == CODE_MDIG_LOAD) || (code == CODE_HBAR_LOAD) ||
			(code == CODE_NBAR_LOAD) || (code == CODE_WBAR_LOAD);
	endfunction : is_bank_load

	localparam logic [7:0] GEN_OUT_MAX = 8'(GEN_OUT_COUNT);

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_CODE = 5'b00010,
		ST_PARAM = 5'b00100,
		ST_EXEC = 5'b01000,
		ST_WAIT = 5'b10000
	} bdoc_state_t;

	bdoc_state_t state_reg;
	bdoc_state_t state_next;
	logic [7:0] code_reg;
	logic [2:0] count_reg;
	logic [2:0] idx_reg;
	logic [7:0] param_reg [0:3];
	logic boot_pending_reg;
	logic [GEN_OUT_COUNT-1:0] gen_out_reg;
	logic bank_load_reg;
	bdoc_bank_t bank_sel_reg;
	bdoc_bank_t active_bank_reg;
	logic nv_we_reg;
	logic [7:0] nv_index_reg;
	logic nv_state_reg;

	bdoc_draw_if drw ();

	bdoc_draw_engine u_engine (
		.clk_in(SYS_CLK_IN),
		.srst_in(SRST_IN),
		.drw(drw.eng)
	);

	// ==========================================================
	// Byte intake
	wire rx_ready = (state_reg == ST_IDLE) || (state_reg == ST_CODE) ||
		(state_reg == ST_PARAM);
	wire accept = RX_VALID_IN && rx_ready;
	wire [2:0] rx_count = param_count(RX_DATA_IN);
	wire rx_known = (rx_count != 3'h0) || is_bank_load(RX_DATA_IN);
	wire last_param = (3'(idx_reg + 3'h1) == count_reg);

	// ==========================================================
	// Parameter checks
	wire [7:0] p0 = param_reg[0];
	wire [7:0] p1 = param_reg[1];
	wire [7:0] p2 = param_reg[2];
	wire [7:0] p3 = param_reg[3];
	wire mdig_ok = in_range(p0, 8'h01, SCREEN_COLS) &&
		in_range(p1, 8'h01, SCREEN_ROWS) &&
		in_range(p2, 8'h00, DIGIT_MAX);
	wire hbar_ok = in_range(p0, 8'h01, SCREEN_COLS) &&
		in_range(p1, 8'h01, SCREEN_ROWS) &&
		in_range(p2, 8'h00, DIR_LEFT) &&
		in_range(p3, 8'h00, HBAR_MAX_LEN);
	wire vbar_ok = in_range(p0, 8'h01, SCREEN_COLS) &&
		in_range(p1, 8'h00, VBAR_MAX_LEN);
	wire out_ok = in_range(p0, 8'h01, GEN_OUT_MAX);
	wire boot_ok = out_ok && in_range(p1, 8'h00, STATE_ON);
	wire exec = (state_reg == ST_EXEC);
	wire draw_go = exec && (((code_reg == CODE_MDIG_PLACE) && mdig_ok) ||
		((code_reg == CODE_HBAR_PLACE) && hbar_ok) ||
		((code_reg == CODE_VBAR_PLACE) && vbar_ok));
	wire [7:0] out_idx = 8'(p0 - 8'h01);
	wire [GEN_OUT_COUNT-1:0] out_mask =
		{{(GEN_OUT_COUNT-1){1'b0}}, 1'b1} << out_idx;
	wire out_on_go = exec && (code_reg == CODE_OUT_ON) && out_ok;
	wire out_off_go = exec && (code_reg == CODE_OUT_OFF) && out_ok;
	wire boot_go = exec && (code_reg == CODE_OUT_BOOT) && boot_ok;

	// ==========================================================
	// Bank selection from code
	wire bank_go = exec && is_bank_load(code_reg);
	wire bdoc_bank_t bank_code =
		(code_reg == CODE_MDIG_LOAD) ? BANK_MDIG :
		(code_reg == CODE_HBAR_LOAD) ? BANK_HBAR :
		(code_reg == CODE_NBAR_LOAD) ? BANK_NBAR :
		(code_reg == CODE_WBAR_LOAD) ? BANK_WBAR : BANK_NONE;

	// ==========================================================
	// Draw request; byte order differs per command
	assign drw.start = draw_go;
	assign drw.kind = (code_reg == CODE_MDIG_PLACE) ? DRAW_MDIG :
		(code_reg == CODE_HBAR_PLACE) ? DRAW_HBAR : DRAW_VBAR;
	assign drw.col = p0;
	assign drw.row = p1;
	assign drw.dir = (code_reg == CODE_HBAR_PLACE) ? p2 : 8'h00;
	assign drw.len = (code_reg == CODE_HBAR_PLACE) ? p3 :
		(code_reg == CODE_MDIG_PLACE) ? p2 : p1;

	// ==========================================================
	// Command sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				// Non-prefix bytes belong to the text path
				if (accept && (RX_DATA_IN == CMD_PREFIX)) begin
					state_next = ST_CODE;
				end
			end
			ST_CODE: begin
				if (accept) begin
					if (!rx_known) begin
						state_next = ST_IDLE;
					end else if (rx_count == 3'h0) begin
						state_next = ST_EXEC;
					end else begin
						state_next = ST_PARAM;
					end
				end
			end
			ST_PARAM: begin
				if (accept && last_param) begin
					state_next = ST_EXEC;
				end
			end
			ST_EXEC: begin
				state_next = draw_go ? ST_WAIT : ST_IDLE;
			end
			ST_WAIT: begin
				// Input stalls while cells are written
				if (!drw.busy) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (SRST_IN) begin
			state_reg <= ST_IDLE;
			code_reg <= 8'h00;
			count_reg <= 3'h0;
			idx_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			if (accept && (state_reg == ST_CODE)) begin
				code_reg <= RX_DATA_IN;
				count_reg <= rx_count;
				idx_reg <= 3'h0;
			end else if (accept && (state_reg == ST_PARAM)) begin
				idx_reg <= 3'(idx_reg + 3'h1);
			end
		end
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (SRST_IN) begin
			for (int i = 0; i < 4; i++) begin
				param_reg[i] <= 8'h00;
			end
		end else if (accept && (state_reg == ST_PARAM)) begin
			param_reg[idx_reg[1:0]] <= RX_DATA_IN;
		end
	end

	// ==========================================================
	// Character bank control
	always_ff @(posedge SYS_CLK_IN) begin
		if (SRST_IN) begin
			bank_load_reg <= 1'b0;
			bank_sel_reg <= BANK_NONE;
			active_bank_reg <= BANK_NONE;
		end else begin
			// Whole active memory is overwritten, unsaved glyphs lost
			bank_load_reg <= bank_go;
			if (bank_go) begin
				bank_sel_reg <= bank_code;
				active_bank_reg <= bank_code;
			end
		end
	end

	// ==========================================================
	// General outputs and start-up image
	always_ff @(posedge SYS_CLK_IN) begin
		if (SRST_IN) begin
			boot_pending_reg <= 1'b1;
			gen_out_reg <= '0;
			nv_we_reg <= 1'b0;
			nv_index_reg <= 8'h00;
			nv_state_reg <= 1'b0;
		end else begin
			// Image taken on the first edge after release
			boot_pending_reg <= 1'b0;
			if (boot_pending_reg) begin
				gen_out_reg <= NV_STATE_IN;
			end else if (out_on_go) begin
				gen_out_reg <= gen_out_reg | out_mask;
			end else if (out_off_go) begin
				gen_out_reg <= gen_out_reg & ~out_mask;
			end
			// Saved state only, live output untouched
			nv_we_reg <= boot_go;
			if (boot_go) begin
				nv_index_reg <= p0;
				nv_state_reg <= (p1 == STATE_ON);
			end
		end
	end

	assign RX_READY_OUT = rx_ready;
	assign BANK_LOAD_OUT = bank_load_reg;
	assign BANK_SEL_OUT = bank_sel_reg;
	assign ACTIVE_BANK_OUT = active_bank_reg;
	assign CELL_WE_OUT = drw.cell_we;
	assign CELL_ROW_OUT = drw.cell_row;
	assign CELL_COL_OUT = drw.cell_col;
	assign CELL_CHAR_OUT = drw.cell_char;
	assign GENERAL_OUTPUT_OUT = gen_out_reg;
	assign NV_WE_OUT = nv_we_reg;
	assign NV_INDEX_OUT = nv_index_reg;
	assign NV_STATE_OUT = nv_state_reg;
endmodule : bdoc_top

// ==== bdoc_host_model.sv ====
`timescale 1ns/1ps
module bdoc_host_model (
	input wire logic clk_in,
	input wire logic rdy_in,
	output logic [7:0] data_out,
	output logic valid_out
);
	logic rdy_seen;
	initial begin
		data_out = 8'h00;
		valid_out = 1'b0;
	end
	// ==========================================================
	// Byte offer, held until a ready edge takes it
	task automatic send(input logic [7:0] q[$]);
		@(posedge clk_in);
		#1;
		foreach (q[k]) begin
			data_out = q[k];
			valid_out = 1'b1;
			do begin
				rdy_seen = rdy_in;
				@(posedge clk_in);
			end while (rdy_seen !== 1'b1);
			#1;
		end
		// Released bus shows junk, not the stale byte
		valid_out = 1'b0;
		data_out = ~data_out;
	endtask : send
endmodule : bdoc_host_model

// ==== bdoc_top_sva.sv ====
`timescale 1ns/1ps
module bdoc_top_chk
	import bdoc_pkg::*;
#(
	parameter int GEN_OUT_COUNT = 8
) (
	input wire logic SYS_CLK_IN,
	input wire logic SRST_IN,
	input wire logic [7:0] RX_DATA_IN,
	input wire logic RX_VALID_IN,
	input wire logic RX_READY_OUT,
	input wire logic BANK_LOAD_OUT,
	input wire logic [2:0] BANK_SEL_OUT,
	input wire logic [2:0] ACTIVE_BANK_OUT,
	input wire logic CELL_WE_OUT,
	input wire logic [2:0] CELL_ROW_OUT,
	input wire logic [4:0] CELL_COL_OUT,
	input wire logic [7:0] CELL_CHAR_OUT,
	input wire logic [GEN_OUT_COUNT-1:0] GENERAL_OUTPUT_OUT,
	input wire logic [GEN_OUT_COUNT-1:0] NV_STATE_IN,
	input wire logic NV_WE_OUT,
	input wire logic [7:0] NV_INDEX_OUT,
	input wire logic NV_STATE_OUT
);
	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (SRST_IN);
	function automatic logic [2:0] bank_of(input logic [7:0] c);
		case (c)
			CODE_MDIG_LOAD: return BANK_MDIG;
			CODE_HBAR_LOAD: return BANK_HBAR;
			CODE_NBAR_LOAD: return BANK_NBAR;
			CODE_WBAR_LOAD: return BANK_WBAR;
			default: return BANK_NONE;
		endcase
	endfunction : bank_of
	// ==========================================================
	// Properties
	property p_bank_cause;
		BANK_LOAD_OUT |-> $past(RX_VALID_IN && RX_READY_OUT, 2);
	endproperty
	property p_bank_map;
		BANK_LOAD_OUT |-> BANK_SEL_OUT == ACTIVE_BANK_OUT &&
			BANK_SEL_OUT == bank_of($past(RX_DATA_IN, 2));
	endproperty
	property p_ready_back;
		!RX_READY_OUT |-> ##[1:40] RX_READY_OUT;
	endproperty
	property p_out_cause;
		// Start-up image load is not a command effect
		$changed(GENERAL_OUTPUT_OUT) && !$past(SRST_IN) &&
			!$past(SRST_IN, 2) |->
			!$past(RX_READY_OUT) &&
			$onehot(GENERAL_OUTPUT_OUT ^ $past(GENERAL_OUTPUT_OUT));
	endproperty
	property p_boot_load;
		$fell(SRST_IN) |=> GENERAL_OUTPUT_OUT == $past(NV_STATE_IN);
	endproperty
	property p_nv_pulse;
		NV_WE_OUT |-> $stable(GENERAL_OUTPUT_OUT) ##1 !NV_WE_OUT;
	endproperty
	property p_cell_range;
		CELL_WE_OUT |-> CELL_ROW_OUT inside {[3'h1:3'h4]} &&
			CELL_COL_OUT inside {[5'h01:5'h14]} && !RX_READY_OUT;
	endproperty
	property p_cell_start;
		$rose(CELL_WE_OUT) |-> !$past(RX_READY_OUT, 2) && !$past(RX_READY_OUT);
	endproperty
	a_bank_cause: assert property (p_bank_cause) else $error("bank cause");
	a_bank_map: assert property (p_bank_map) else $error("bank map");
	a_ready_back: assert property (p_ready_back) else $error("stuck");
	a_out_cause: assert property (p_out_cause) else $error("out");
	a_boot_load: assert property (p_boot_load) else $error("boot");
	a_nv_pulse: assert property (p_nv_pulse) else $error("nv");
	a_cell_range: assert property (p_cell_range) else $error("cell");
	a_cell_start: assert property (p_cell_start) else $error("start");
	c_bank: cover property (BANK_LOAD_OUT);
	c_cell: cover property (CELL_WE_OUT);
	c_nv: cover property (NV_WE_OUT);
endmodule : bdoc_top_chk

bind bdoc_top bdoc_top_chk #(.GEN_OUT_COUNT(GEN_OUT_COUNT))
	bdoc_top_chk_i (.*);

// ==== bar_digit_output_cmds_test.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin \
	checks++; \
	if ((g) !== (e)) begin \
		num_errors++; \
		$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
	end \
end
module bar_digit_output_cmds_test import bdoc_pkg::*;;
	logic clk, srst, v, rdy, bload, cwe, nvwe, nvst;
	logic [7:0] d, cchar, nvidx, gout, nvin, exp_out;
	logic [2:0] bsel, abank, crow, bank_seen;
	logic [4:0] ccol;
	logic [8:0] nv_seen;
	logic [15:0] got[$];
	int num_errors = 0;
	int checks = 0;
	int cyc = 0;
	int bank_n, nv_n;
	bdoc_top bdoc_top_i (.SYS_CLK_IN(clk), .SRST_IN(srst), .RX_DATA_IN(d),
		.RX_VALID_IN(v), .RX_READY_OUT(rdy), .BANK_LOAD_OUT(bload),
		.BANK_SEL_OUT(bsel), .ACTIVE_BANK_OUT(abank), .CELL_WE_OUT(cwe),
		.CELL_ROW_OUT(crow), .CELL_COL_OUT(ccol), .CELL_CHAR_OUT(cchar),
		.GENERAL_OUTPUT_OUT(gout), .NV_STATE_IN(nvin), .NV_WE_OUT(nvwe),
		.NV_INDEX_OUT(nvidx), .NV_STATE_OUT(nvst));
	bdoc_host_model bdoc_host_model_i (.clk_in(clk), .rdy_in(rdy),
		.data_out(d), .valid_out(v));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			test_done();
		end
	end
	// ==========================================================
	// Helpers
	function automatic logic [7:0] lvl(input int len, input int i, int px);
		int x;
		x = len - px * i;
		if (x > px)
			x = px;
		if (x <= 0)
			return BLANK_CHAR;
		return BAR_GLYPH_BASE + 8'(x - 1);
	endfunction : lvl
	task automatic do_reset(input logic [7:0] nv);
		@(posedge clk);
		#1;
		srst = 1'b1;
		nvin = nv;
		repeat (8) @(posedge clk);
		#1;
		srst = 1'b0;
		@(posedge clk);
		#1;
		exp_out = nv;
		`CHK(gout, exp_out)
	endtask : do_reset
	task automatic run(input logic [7:0] q[$], input int n);
		got = {};
		bank_n = 0;
		nv_n = 0;
		bdoc_host_model_i.send(q);
		repeat (n) begin
			@(posedge clk);
			#1;
			if (cwe === 1'b1)
				got.push_back({crow, ccol, cchar});
			if (bload === 1'b1) begin
				bank_n++;
				bank_seen = bsel;
			end
			if (nvwe === 1'b1) begin
				nv_n++;
				nv_seen = {nvidx, nvst};
			end
		end
	endtask : run
	task automatic chk_cells(input logic [15:0] e[$]);
		`CHK(got.size(), e.size())
		foreach (e[k])
			if (k < got.size()) `CHK(got[k], e[k])
	endtask : chk_cells
	// ==========================================================
	// Scenarios
	task automatic t_banks;
		logic [7:0] c[4] = '{CODE_MDIG_LOAD, CODE_HBAR_LOAD, CODE_NBAR_LOAD,
			CODE_WBAR_LOAD};
		for (int k = 0; k < 4; k++) begin
			run('{CMD_PREFIX, c[k]}, 5);
			`CHK(bank_n, 1)
			`CHK(bank_seen, 3'(k + 1))
			`CHK(abank, 3'(k + 1))
		end
	endtask : t_banks
	task automatic t_gpo;
		bdoc_host_model_i.send('{CMD_PREFIX, CODE_OUT_ON});
		repeat (6) @(posedge clk);
		#1;
		`CHK(gout, exp_out)
		run('{8'h01}, 4);
		exp_out[0] = 1'b1;
		for (int k = 1; k <= 10; k++) begin
			`CHK(gout, exp_out)
			run('{CMD_PREFIX, (k % 2) ? CODE_OUT_OFF : CODE_OUT_ON, 8'(k)}, 4);
			if (k <= 8)
				exp_out[k - 1] = ~k[0];
		end
		`CHK(gout, exp_out)
	endtask : t_gpo
	task automatic t_nv;
		run('{CMD_PREFIX, CODE_OUT_BOOT, 8'h02, 8'h01}, 5);
		`CHK(nv_seen, {8'h02, 1'b1})
		`CHK(gout, exp_out)
		run('{CMD_PREFIX, CODE_OUT_BOOT, 8'h08, 8'h00}, 5);
		`CHK(nv_seen, {8'h08, 1'b0})
		run('{CMD_PREFIX, CODE_OUT_BOOT, 8'h03, 8'h02}, 5);
		`CHK(nv_n, 0)
		do_reset(8'ha5);
	endtask : t_nv
	task automatic t_mdig(input int c, input int r, input int g);
		logic [15:0] e[$];
		if (c <= 20 && r <= 4 && g <= 9) begin
			e.push_back({3'(r), 5'(c), MDIG_GLYPH_BASE + 8'(2 * g)});
			if (r < 4)
				e.push_back({3'(r + 1), 5'(c), MDIG_GLYPH_BASE + 8'(2 * g + 1)});
		end
		run('{CMD_PREFIX, CODE_MDIG_PLACE, 8'(c), 8'(r), 8'(g)}, 8);
		chk_cells(e);
	endtask : t_mdig
	task automatic t_hbar(input int c, input int r, input int dr, int len);
		logic [15:0] e[$];
		int i;
		i = 0;
		if (len <= 100 && r <= 4)
			for (int x = c; x >= 1 && x <= 20; x += dr ? -1 : 1) begin
				e.push_back({3'(r), 5'(x), lvl(len, i, 5)});
				i++;
			end
		run('{CMD_PREFIX, CODE_HBAR_PLACE, 8'(c), 8'(r), 8'(dr), 8'(len)}, 26);
		chk_cells(e);
	endtask : t_hbar
	task automatic t_vbar(input int c, input int len);
		logic [15:0] e[$];
		if (len <= 32)
			for (int r = 1; r <= 4; r++)
				e.push_back({3'(r), 5'(c), lvl(len, r - 1, 8)});
		run('{CMD_PREFIX, CODE_VBAR_PLACE, 8'(c), 8'(len)}, 10);
		chk_cells(e);
	endtask : t_vbar
	task test_done;
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	initial begin
		srst = 1'b1;
		nvin = 8'h5a;
		do_reset(8'h5a);
		t_banks();
		t_gpo();
		t_nv();
		run('{CMD_PREFIX, CODE_MDIG_LOAD}, 4);
		t_mdig(5, 3, 7);
		t_mdig(20, 4, 0);
		t_mdig(21, 1, 1);
		t_mdig(2, 2, 10);
		run('{CMD_PREFIX, CODE_HBAR_LOAD}, 4);
		t_hbar(18, 2, 0, 12);
		t_hbar(3, 4, 1, 7);
		t_hbar(1, 3, 0, 100);
		t_hbar(4, 2, 0, 101);
		run('{CMD_PREFIX, CODE_WBAR_LOAD}, 4);
		t_vbar(3, 10);
		t_vbar(20, 32);
		t_vbar(7, 33);
		test_done();
	end
endmodule : bar_digit_output_cmds_test
